// [design/pssd_pkg.sv]
// Shared types and constants of the symbol sign and receive decode block
`default_nettype none
package pssd_pkg;
   // Quinary symbol and four-lane vector
   typedef logic signed [2:0] pssd_sym_t;
   typedef struct packed {
      pssd_sym_t a;
      pssd_sym_t b;
      pssd_sym_t c;
      pssd_sym_t d;
   } pssd_vec_t;
   // Transmit code-group kinds
   typedef enum logic [2:0] {
      PSSD_GRP_NORMAL = 3'h0,
      PSSD_GRP_XMT_ERR = 3'h1,
      PSSD_GRP_EXT_ERR = 3'h2,
      PSSD_GRP_EXTEND = 3'h3,
      PSSD_GRP_RESET = 3'h4
   } pssd_grp_t;
   // Receive states, one-hot
   typedef enum logic [6:0] {
      PSSD_ST_IDLE = 7'h01,
      PSSD_ST_SSD2 = 7'h02,
      PSSD_ST_DATA = 7'h04,
      PSSD_ST_SECOND_END_GROUP = 7'h08,
      PSSD_ST_CEXT = 7'h10,
      PSSD_ST_ERR = 7'h20,
      PSSD_ST_LFAIL = 7'h40
   } pssd_state_t;
   // Status word layout
   typedef struct packed {
      logic [27:0] zero;
      logic rem_lpi_req;
      logic remote_stream_active;
      logic rx_error;
      logic scr_ok;
   } pssd_status_t;
   // Register map
   localparam logic [7:0] PSSD_ADDR_CTRL = 8'h00;
   localparam logic [7:0] PSSD_ADDR_STATUS = 8'h04;
   localparam int PSSD_CTRL_EEE_BIT = 0;
   localparam logic PSSD_CTRL_EEE_RST = 1'b0;
   // Descrambler
   localparam int PSSD_SCR_LEN = 33;
   localparam int PSSD_TAP_MASTER = 20;
   localparam int PSSD_TAP_SLAVE = 13;
   localparam logic [5:0] PSSD_LOCK_MATCHES = 6'h28;
   // Transmit enable history depth and sign-reverse taps
   localparam int PSSD_TXEN_DEPTH = 4;
   localparam int PSSD_TXEN_TAP2 = 1;
   localparam int PSSD_TXEN_TAP4 = 3;
   // Idle vectors needed to leave the error state
   localparam logic [2:0] PSSD_IDLE_EXIT = 3'h4;
   localparam logic [2:0] PSSD_IDLE_DV_KEEP = 3'h3;
   // GMII receive codes
   localparam logic [7:0] PSSD_PREAMBLE = 8'h55;
   localparam logic [7:0] PSSD_CEXT_CODE = 8'h0f;
   localparam logic [7:0] PSSD_LPI_CODE = 8'h01;
   localparam logic [3:0] PSSD_UPD_COUNT = 4'h8;
   // Delimiter and low-power patterns
   localparam pssd_vec_t PSSD_SSD1 = {3'h2, 3'h2, 3'h2, 3'h2};
   localparam pssd_vec_t PSSD_SSD2 = {3'h2, 3'h2, 3'h2, 3'h6};
   localparam pssd_vec_t PSSD_ESD1 = {3'h2, 3'h2, 3'h6, 3'h6};
   localparam pssd_vec_t PSSD_SECOND_END_GROUP_EXT0 = {3'h2, 3'h6, 3'h2, 3'h6};
   localparam pssd_vec_t PSSD_SECOND_END_GROUP_EXT1 = {3'h6, 3'h2, 3'h2, 3'h6};
   localparam pssd_vec_t PSSD_SECOND_END_GROUP_EXT2 = {3'h6, 3'h6, 3'h2, 3'h2};
   localparam pssd_vec_t PSSD_LPI_IDLE = {3'h0, 3'h0, 3'h2, 3'h2};
endpackage
`default_nettype wire

// [design/pssd_top.sv]
// Transmit symbol sign generation and receive decode with descrambler
//
// Overview of operation
// RULE1 - Normal data rows map to quinary tuples
// RULE2 - Special groups depend only on high bits
// RULE3 - Four sign bits randomize lane polarity
// RULE4 - Sign reverse is enable at n-2 or n-4
// RULE5 - Sign is minus when bit xor reverse zero
// RULE6 - Lane symbol is mapped symbol times sign
// RULE7 - Align vectors, report descrambler lock OK
// RULE8 - Drive data, valid, error and stream flag
// RULE9 - Derive remote low-power indications from idle
// RULE10 - Idle violation sets stream flag, checks two
// RULE11 - Start delimiter periods carry preamble bits
// RULE12 - Valid asserted, vectors decoded until end
// RULE13 - Error cleared after four idle vectors
// RULE14 - Plus minus two symbols checked for end
// RULE15 - End drops valid, extension raises error
// RULE16 - No extension clears flag, else after idle
// RULE17 - Any violation gives error one period
// RULE18 - Mid-stream error keeps valid three idles; code keeps valid until the error state exits after four idles
// RULE19 - Error asserted while link has failed
// RULE20 - Descramble with role dependent polynomial
// RULE21 - Role comes from the PMA configuration
// RULE22 - Error status is ERROR or NO_ERROR
// RULE23 - Descrambler is a 33 stage shift register
// RULE24 - Transmit enable kept in four stage history
`default_nettype none
module pssd_top
   import pssd_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Register port
   input wire logic [7:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   // Transmit side
   input wire logic [8:0] i_scrambled_data_bits,
   input wire pssd_grp_t i_tx_group,
   input wire logic [3:0] i_sign_scrambler_bits,
   input wire logic i_tx_enable,
   output pssd_vec_t o_tx_symbols,
   // PMA side
   input wire pssd_vec_t i_rx_symbols,
   input wire logic i_config_master,
   input wire logic i_loc_rcvr_ok,
   input wire logic i_link_ok,
   // GMII receive side
   output logic [7:0] o_rxd,
   output logic o_rx_dv,
   output logic o_rx_er,
   output logic o_remote_stream_active,
   output logic o_scr_ok,
   output logic o_rx_error_status,
   output logic o_rem_lpi_req,
   output logic o_rem_update_done
);

   function automatic pssd_vec_t mk(input int a, input int b, input int c, input int d);
      mk = {3'(a), 3'(b), 3'(c), 3'(d)};
   endfunction

   // RULE1 normal row lookup
   function automatic pssd_vec_t map_normal(input logic [5:0] low, input logic [1:0] col);
      case ({low, col})
         {6'h35, 2'h0}: map_normal = mk(-2, 2, 0, -1);
         {6'h35, 2'h1}: map_normal = mk(-2, 2, 1, -2);
         {6'h35, 2'h2}: map_normal = mk(-1, 2, 0, -2);
         {6'h35, 2'h3}: map_normal = mk(-1, 2, 1, -1);
         {6'h36, 2'h0}: map_normal = mk(0, 2, -2, -1);
         {6'h36, 2'h1}: map_normal = mk(0, 2, -1, -2);
         {6'h36, 2'h2}: map_normal = mk(1, 2, -2, -2);
         {6'h36, 2'h3}: map_normal = mk(1, 2, -1, -1);
         {6'h37, 2'h0}: map_normal = mk(-2, 2, -2, -1);
         {6'h37, 2'h1}: map_normal = mk(-2, 2, -1, -2);
         {6'h37, 2'h2}: map_normal = mk(-1, 2, -2, -2);
         {6'h37, 2'h3}: map_normal = mk(-1, 2, -1, -1);
         {6'h38, 2'h0}: map_normal = mk(1, 1, 1, 2);
         {6'h38, 2'h1}: map_normal = mk(0, 0, 1, 2);
         {6'h38, 2'h2}: map_normal = mk(1, 0, 0, 2);
         {6'h38, 2'h3}: map_normal = mk(0, 1, 0, 2);
         {6'h39, 2'h0}: map_normal = mk(-1, 1, 1, 2);
         {6'h39, 2'h1}: map_normal = mk(-2, 0, 1, 2);
         {6'h39, 2'h2}: map_normal = mk(-1, 0, 0, 2);
         {6'h39, 2'h3}: map_normal = mk(-2, 1, 0, 2);
         {6'h3a, 2'h0}: map_normal = mk(1, -1, 1, 2);
         {6'h3a, 2'h1}: map_normal = mk(0, -2, 1, 2);
         {6'h3a, 2'h2}: map_normal = mk(1, -2, 0, 2);
         {6'h3a, 2'h3}: map_normal = mk(0, -1, 0, 2);
         {6'h3b, 2'h0}: map_normal = mk(-1, -1, 1, 2);
         {6'h3b, 2'h1}: map_normal = mk(-2, -2, 1, 2);
         {6'h3b, 2'h2}: map_normal = mk(-1, -2, 0, 2);
         {6'h3b, 2'h3}: map_normal = mk(-2, -1, 0, 2);
         {6'h3c, 2'h0}: map_normal = mk(1, 1, -1, 2);
         {6'h3c, 2'h1}: map_normal = mk(0, 0, -1, 2);
         {6'h3c, 2'h2}: map_normal = mk(1, 0, -2, 2);
         {6'h3c, 2'h3}: map_normal = mk(0, 1, -2, 2);
         {6'h3d, 2'h0}: map_normal = mk(-1, 1, -1, 2);
         {6'h3d, 2'h1}: map_normal = mk(-2, 0, -1, 2);
         {6'h3d, 2'h2}: map_normal = mk(-1, 0, -2, 2);
         {6'h3d, 2'h3}: map_normal = mk(-2, 1, -2, 2);
         {6'h3e, 2'h0}: map_normal = mk(1, -1, -1, 2);
         {6'h3e, 2'h1}: map_normal = mk(0, -2, -1, 2);
         {6'h3e, 2'h2}: map_normal = mk(1, -2, -2, 2);
         {6'h3e, 2'h3}: map_normal = mk(0, -1, -2, 2);
         {6'h3f, 2'h0}: map_normal = mk(-1, -1, -1, 2);
         {6'h3f, 2'h1}: map_normal = mk(-2, -2, -1, 2);
         {6'h3f, 2'h2}: map_normal = mk(-1, -2, -2, 2);
         {6'h3f, 2'h3}: map_normal = mk(-2, -1, -2, 2);
         default: map_normal = mk(0, 0, 0, 0);
      endcase
   endfunction

   // RULE2 special groups by column only
   function automatic pssd_vec_t map_special(input pssd_grp_t grp, input logic [1:0] col);
      case ({grp, col})
         {PSSD_GRP_XMT_ERR, 2'h0}: map_special = mk(2, 2, 0, 1);
         {PSSD_GRP_XMT_ERR, 2'h1}: map_special = mk(0, 2, 1, 2);
         {PSSD_GRP_XMT_ERR, 2'h2}: map_special = mk(1, 2, 2, 0);
         {PSSD_GRP_XMT_ERR, 2'h3}: map_special = mk(2, 1, 2, 0);
         {PSSD_GRP_EXT_ERR, 2'h0}: map_special = mk(2, 2, -2, -1);
         {PSSD_GRP_EXT_ERR, 2'h1}: map_special = mk(-2, 2, -1, 2);
         {PSSD_GRP_EXT_ERR, 2'h2}: map_special = mk(-1, 2, 2, -2);
         {PSSD_GRP_EXT_ERR, 2'h3}: map_special = mk(2, -1, 2, -2);
         {PSSD_GRP_EXTEND, 2'h0}: map_special = mk(2, 0, 2, 1);
         {PSSD_GRP_EXTEND, 2'h1}: map_special = mk(2, 0, 1, 2);
         {PSSD_GRP_EXTEND, 2'h2}: map_special = mk(1, 0, 2, 2);
         {PSSD_GRP_EXTEND, 2'h3}: map_special = mk(2, 1, 0, 2);
         {PSSD_GRP_RESET, 2'h0}: map_special = mk(2, -2, 2, -1);
         {PSSD_GRP_RESET, 2'h1}: map_special = mk(2, -2, -1, 2);
         {PSSD_GRP_RESET, 2'h2}: map_special = mk(-1, -2, 2, 2);
         {PSSD_GRP_RESET, 2'h3}: map_special = mk(2, -1, -2, 2);
         default: map_special = mk(0, 0, 0, 0);
      endcase
   endfunction

   function automatic logic is_even(input pssd_vec_t v);
      is_even = !v.a[0] && !v.b[0] && !v.c[0] && !v.d[0];
   endfunction

   function automatic logic has_two(input pssd_vec_t v);
      has_two = v.a[1:0] == 2'h2 || v.b[1:0] == 2'h2 || v.c[1:0] == 2'h2
         || v.d[1:0] == 2'h2;
   endfunction

   // Transmit datapath
   logic [1:0] tx_col;
   pssd_vec_t unsigned_mapped_symbol;
   logic [PSSD_TXEN_DEPTH-1:0] txen_hist;
   logic srev;
   logic [3:0] lane_binary_sign;
   pssd_vec_t next_tx_symbols;

   assign tx_col = {i_scrambled_data_bits[6], i_scrambled_data_bits[7]};
   assign unsigned_mapped_symbol = (i_tx_group == PSSD_GRP_NORMAL)
      ? map_normal(i_scrambled_data_bits[5:0], tx_col) : map_special(i_tx_group, tx_col);

   // RULE24 enable history
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         txen_hist <= '0;
      else
         txen_hist <= {txen_hist[PSSD_TXEN_DEPTH-2:0], i_tx_enable};
   end

   // RULE4 sign reverse
   assign srev = txen_hist[PSSD_TXEN_TAP2] | txen_hist[PSSD_TXEN_TAP4];

   genvar lane;
   generate
      for (lane = 0; lane < 4; lane++)
      begin : g_lane
         pssd_sym_t t_sym;
         assign t_sym = unsigned_mapped_symbol[3*(3-lane) +: 3];
         // RULE3 RULE5 sign per lane, high means minus
         assign lane_binary_sign[lane] = ((i_sign_scrambler_bits[lane] ^ srev) == 1'b0);
         // RULE6 product with sign
         assign next_tx_symbols[3*(3-lane) +: 3] = lane_binary_sign[lane] ? -t_sym : t_sym;
      end
   endgenerate

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         o_tx_symbols <= '0;
      else
         o_tx_symbols <= next_tx_symbols;
   end

   // Register port
   logic eee_enable;
   pssd_status_t status_word;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         eee_enable <= PSSD_CTRL_EEE_RST;
      else if (i_reg_wr && i_reg_addr == PSSD_ADDR_CTRL)
         eee_enable <= i_reg_wdata[PSSD_CTRL_EEE_BIT];
   end

   assign status_word = '{zero: '0, rem_lpi_req: o_rem_lpi_req,
      remote_stream_active: o_remote_stream_active, rx_error: o_rx_error_status,
      scr_ok: o_scr_ok};

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         o_reg_rdata <= '0;
      else if (i_reg_rd && i_reg_addr == PSSD_ADDR_CTRL)
         o_reg_rdata <= 32'(eee_enable);
      else if (i_reg_rd && i_reg_addr == PSSD_ADDR_STATUS)
         o_reg_rdata <= status_word;
      else
         o_reg_rdata <= '0;
   end

   // Descrambler
   logic [PSSD_SCR_LEN-1:0] scr;
   logic scr_fb;
   logic rx_bit;
   logic [5:0] lock_cnt;

   assign rx_bit = i_rx_symbols.a[2];
   // RULE20 RULE21 role selects the tap
   assign scr_fb = scr[PSSD_SCR_LEN-1]
      ^ (i_config_master ? scr[PSSD_TAP_MASTER-1] : scr[PSSD_TAP_SLAVE-1]);

   // RULE23 one shift per symbol period
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         scr <= '0;
      else if (o_scr_ok)
         scr <= {scr[PSSD_SCR_LEN-2:0], scr_fb};
      else
         scr <= {scr[PSSD_SCR_LEN-2:0], rx_bit};
   end

   // RULE7 lock after matching idle bits
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b || !i_loc_rcvr_ok)
      begin
         lock_cnt <= '0;
         o_scr_ok <= 1'b0;
      end
      else if (!o_scr_ok)
      begin
         if (scr_fb != rx_bit)
            lock_cnt <= '0;
         else if (lock_cnt == PSSD_LOCK_MATCHES - 6'h1)
            o_scr_ok <= 1'b1;
         else
            lock_cnt <= lock_cnt + 6'h1;
      end
   end

   // Receive state machine
   pssd_state_t state;
   pssd_state_t next_state;
   logic idle_ok;
   logic [2:0] idle_cnt;
   logic err_in_data;
   logic [7:0] rx_octet;

   assign idle_ok = is_even(i_rx_symbols) && i_rx_symbols != PSSD_SSD1;
   assign rx_octet = {i_rx_symbols.a[1:0], i_rx_symbols.b[1:0], i_rx_symbols.c[1:0],
      i_rx_symbols.d[1:0]} ^ scr[7:0];

   always_comb
   begin
      next_state = state;
      case (state)
         PSSD_ST_IDLE:
            // RULE10 idle violation check
            if (o_scr_ok && !idle_ok)
               next_state = (i_rx_symbols == PSSD_SSD1) ? PSSD_ST_SSD2 : PSSD_ST_ERR;
         PSSD_ST_SSD2:
            next_state = (i_rx_symbols == PSSD_SSD2) ? PSSD_ST_DATA : PSSD_ST_ERR;
         PSSD_ST_DATA:
            // RULE14 plus minus two end check
            if (i_rx_symbols == PSSD_ESD1)
               next_state = PSSD_ST_SECOND_END_GROUP;
            else if (has_two(i_rx_symbols))
               next_state = PSSD_ST_ERR;
         PSSD_ST_SECOND_END_GROUP:
            if (i_rx_symbols == PSSD_SECOND_END_GROUP_EXT0 || i_rx_symbols == PSSD_SECOND_END_GROUP_EXT1)
               next_state = PSSD_ST_IDLE;
            else if (i_rx_symbols == PSSD_SECOND_END_GROUP_EXT2)
               next_state = PSSD_ST_CEXT;
            else
               next_state = PSSD_ST_ERR;
         PSSD_ST_CEXT:
            if (idle_ok)
               next_state = PSSD_ST_IDLE;
         PSSD_ST_ERR:
            if (idle_ok && idle_cnt == PSSD_IDLE_EXIT - 3'h1)
               next_state = PSSD_ST_IDLE;
         PSSD_ST_LFAIL:
            next_state = PSSD_ST_IDLE;
         default:
            next_state = PSSD_ST_IDLE;
      endcase
      if (!i_link_ok)
         next_state = PSSD_ST_LFAIL;
      else if (!i_loc_rcvr_ok && state != PSSD_ST_LFAIL)
         next_state = PSSD_ST_IDLE;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         state <= PSSD_ST_IDLE;
      else
         state <= next_state;
   end

   // Idle counter for error recovery
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b || state != PSSD_ST_ERR || !idle_ok)
         idle_cnt <= '0;
      else
         idle_cnt <= idle_cnt + 3'h1;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         err_in_data <= 1'b0;
      else if (state != PSSD_ST_ERR)
         err_in_data <= (state == PSSD_ST_DATA || state == PSSD_ST_SSD2);
   end

   // GMII outputs, registered from the state entered
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_rxd <= '0;
         o_rx_dv <= 1'b0;
         o_rx_er <= 1'b0;
      end
      else
      begin
         o_rxd <= '0;
         o_rx_dv <= 1'b0;
         o_rx_er <= 1'b0;
         case (next_state)
            // RULE11 preamble over start delimiter
            PSSD_ST_SSD2:
            begin
               o_rxd <= PSSD_PREAMBLE;
               o_rx_dv <= 1'b1;
            end
            PSSD_ST_DATA:
            begin
               // RULE12 decoded data with valid
               o_rxd <= (state == PSSD_ST_SSD2) ? PSSD_PREAMBLE : rx_octet;
               o_rx_dv <= 1'b1;
            end
            // RULE15 extension signals error
            PSSD_ST_CEXT:
            begin
               o_rxd <= PSSD_CEXT_CODE;
               o_rx_er <= 1'b1;
            end
            // RULE13 RULE17 RULE18 error held until idles
            PSSD_ST_ERR:
            begin
               o_rx_er <= 1'b1;
               o_rx_dv <= (state == PSSD_ST_ERR) ? err_in_data
                  : (state == PSSD_ST_DATA || state == PSSD_ST_SSD2);
            end
            // RULE19 error in link failure
            PSSD_ST_LFAIL:
               o_rx_er <= 1'b1;
            PSSD_ST_IDLE:
               if (eee_enable && o_rem_lpi_req)
               begin
                  o_rxd <= PSSD_LPI_CODE;
                  o_rx_er <= 1'b1;
               end
            default:
               o_rxd <= '0;
         endcase
      end
   end

   // RULE8 RULE10 RULE16 stream activity flag
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         o_remote_stream_active <= 1'b0;
      else
         o_remote_stream_active <= (next_state != PSSD_ST_IDLE)
            && (next_state != PSSD_ST_LFAIL);
   end

   // RULE22 error status set only here
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         o_rx_error_status <= 1'b0;
      else if (next_state == PSSD_ST_ERR)
         o_rx_error_status <= 1'b1;
      else if (next_state == PSSD_ST_IDLE)
         o_rx_error_status <= 1'b0;
   end

   // RULE9 remote low-power from idle encoding
   logic [3:0] lpi_cnt;
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b || !eee_enable || state != PSSD_ST_IDLE || i_rx_symbols != PSSD_LPI_IDLE)
      begin
         lpi_cnt <= '0;
         o_rem_lpi_req <= 1'b0;
         o_rem_update_done <= 1'b0;
      end
      else
      begin
         o_rem_lpi_req <= 1'b1;
         if (lpi_cnt == PSSD_UPD_COUNT - 4'h1)
            o_rem_update_done <= 1'b1;
         else
            lpi_cnt <= lpi_cnt + 4'h1;
      end
   end

endmodule
`default_nettype wire

// [verification/pssd_checker.sv]
// Assertion checker for the symbol sign and receive decode block
`default_nettype none
module pssd_checker
   import pssd_pkg::*;
(
   // Clock, reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Transmit
   input wire logic [8:0] i_scrambled_data_bits,
   input wire pssd_grp_t i_tx_group,
   input wire logic [3:0] i_sign_scrambler_bits,
   input wire logic i_tx_enable,
   input wire pssd_vec_t o_tx_symbols,
   // Receive
   input wire pssd_vec_t i_rx_symbols,
   input wire logic i_loc_rcvr_ok,
   input wire logic i_link_ok,
   input wire logic [7:0] o_rxd,
   input wire logic o_rx_dv,
   input wire logic o_rx_er,
   input wire logic o_remote_stream_active,
   input wire logic o_scr_ok,
   input wire logic o_rx_error_status,
   input wire logic o_rem_lpi_req
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] idle_run;
   logic idle_ok;
   assign idle_ok = !(|(i_rx_symbols & 12'h249)) && i_rx_symbols != PSSD_SSD1;
   // Run of idle-valid vectors
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b || !idle_ok)
         idle_run <= 3'h0;
      else if (idle_run != 3'h7)
         idle_run <= idle_run + 3'h1;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   sequence s_esd1;
      o_rx_dv ##1 (o_rx_dv && !o_rx_er && i_rx_symbols == PSSD_ESD1);
   endsequence
   a_special_map: assert property (
      i_tx_group == PSSD_GRP_XMT_ERR && i_scrambled_data_bits[7:6] == 2'h0
      && i_sign_scrambler_bits == 4'hf && !$past(i_tx_enable, 2) && !$past(i_tx_enable, 4)
      |=> o_tx_symbols == 12'h481) else $error("transmit error group wrong");
   a_sign_lane_a: assert property (
      i_tx_group == PSSD_GRP_XMT_ERR && i_scrambled_data_bits[7:6] == 2'h0
      |=> o_tx_symbols.a == (($past(i_sign_scrambler_bits[0])
      ^ ($past(i_tx_enable, 3) | $past(i_tx_enable, 5))) ? 3'h2 : 3'h6))
      else $error("lane a sign wrong");
   a_lock_lost: assert property (
      !i_loc_rcvr_ok |=> !o_scr_ok) else $error("lock kept without receiver");
   a_preamble_start: assert property (
      $rose(o_rx_dv) |-> o_rxd == PSSD_PREAMBLE && o_remote_stream_active)
      else $error("stream start without preamble");
   a_err_exit: assert property (
      $fell(o_rx_error_status) |-> idle_run >= 3'h4) else $error("error left too early");
   a_err_flags: assert property (
      o_rx_error_status |-> o_rx_er) else $error("error status without rx error");
   a_esd_drop: assert property (
      s_esd1 |=> !o_rx_dv) else $error("valid kept after end");
   a_ext0_clear: assert property (
      s_esd1 ##1 i_rx_symbols == PSSD_SECOND_END_GROUP_EXT0 |=> !o_remote_stream_active && !o_rx_er)
      else $error("stream flag kept after end");
   a_ext2_error: assert property (
      s_esd1 ##1 i_rx_symbols == PSSD_SECOND_END_GROUP_EXT2 |=> o_rx_er && o_rxd == PSSD_CEXT_CODE)
      else $error("extension not flagged");
   a_link_fail: assert property (
      !i_link_ok |=> o_rx_er) else $error("no error on link fail");
   c_frame_end: cover property (s_esd1);
   c_err_exit: cover property ($fell(o_rx_error_status));
   c_lpi: cover property ($rose(o_rem_lpi_req));
endmodule
bind pssd_top pssd_checker u_pssd_checker (
   .i_clk, .i_rst_b, .i_scrambled_data_bits, .i_tx_group, .i_sign_scrambler_bits,
   .i_tx_enable, .o_tx_symbols, .i_rx_symbols, .i_loc_rcvr_ok, .i_link_ok, .o_rxd,
   .o_rx_dv, .o_rx_er, .o_remote_stream_active, .o_scr_ok, .o_rx_error_status,
   .o_rem_lpi_req
);
`default_nettype wire

// [verification/pssd_pma_model.sv]
// Far-end symbol source: scrambled idle or commanded vectors
`default_nettype none
module pssd_pma_model
   import pssd_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Control
   input wire logic i_master,
   input wire logic i_use_vec,
   input wire pssd_vec_t i_vec,
   // Symbols toward the block
   output pssd_vec_t o_symbols
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [32:0] scr;
   logic fb;
   assign fb = scr[32] ^ (i_master ? scr[19] : scr[12]);
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         scr <= 33'h1a5a5a5a5;
      else
         scr <= {scr[31:0], fb};
   end
   // Idle carries the scrambler bit as lane a sign
   assign o_symbols = i_use_vec ? i_vec : {(fb ? 3'h6 : 3'h0), 9'h000};
endmodule
`default_nettype wire

// [verification/pssd_top_test.sv]
// Self-checking bench for the symbol sign and receive decode block
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module pssd_top_test
   import pssd_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [7:0] i_reg_addr = 8'h00;
   logic [31:0] i_reg_wdata = 32'h0;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [8:0] i_scrambled_data_bits = 9'h000;
   pssd_grp_t i_tx_group = PSSD_GRP_NORMAL;
   logic [3:0] i_sign_scrambler_bits = 4'h0;
   logic i_tx_enable = 1'b0;
   logic i_config_master = 1'b1;
   logic i_loc_rcvr_ok = 1'b1;
   logic i_link_ok = 1'b1;
   logic pma_master = 1'b0;
   logic use_vec = 1'b0;
   pssd_vec_t vec = '0;
   pssd_vec_t i_rx_symbols;
   pssd_vec_t o_tx_symbols;
   logic [31:0] o_reg_rdata;
   logic [7:0] o_rxd;
   logic o_rx_dv, o_rx_er, o_remote_stream_active, o_scr_ok;
   logic o_rx_error_status, o_rem_lpi_req, o_rem_update_done;
   int n_errors = 0;
   int cmp_count = 0;
   pssd_top u_pssd_top (
      .i_clk, .i_rst_b, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
      .i_scrambled_data_bits, .i_tx_group, .i_sign_scrambler_bits, .i_tx_enable,
      .o_tx_symbols, .i_rx_symbols, .i_config_master, .i_loc_rcvr_ok, .i_link_ok,
      .o_rxd, .o_rx_dv, .o_rx_er, .o_remote_stream_active, .o_scr_ok,
      .o_rx_error_status, .o_rem_lpi_req, .o_rem_update_done
   );
   pssd_pma_model u_pssd_pma_model (
      .i_clk, .i_rst_b, .i_master(pma_master), .i_use_vec(use_vec), .i_vec(vec),
      .o_symbols(i_rx_symbols)
   );
   always #5 i_clk = ~i_clk;
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      #1;
      `CHK(o_reg_rdata, e)
   endtask
   task automatic tx(input pssd_grp_t g, input logic [8:0] d, input logic [3:0] s,
      input logic en);
      @(posedge i_clk);
      i_tx_group <= g;
      i_scrambled_data_bits <= d;
      i_sign_scrambler_bits <= s;
      i_tx_enable <= en;
      #1;
   endtask
   task automatic step(input pssd_vec_t v, input logic u);
      @(posedge i_clk);
      use_vec <= u;
      vec <= v;
      #1;
   endtask
   task automatic t_tx_map;
      logic [27:0] tbl [10] = '{28'h03ffffa, 28'h03f024e, 28'h0fffdf2, 28'h0bffdba,
         28'h03853ce, 28'h215f481, 28'h42af4b7, 28'h600f411, 28'h9c0f5f2, 28'h010f000};
      for (int i = 0; i < 10; i++)
      begin
         repeat (2) tx(pssd_grp_t'(tbl[i][27:25]), tbl[i][24:16], tbl[i][15:12], 1'b0);
         `CHK(o_tx_symbols, tbl[i][11:0]) // mapping
      end
      $display("t_tx_map done");
   endtask
   task automatic t_srev;
      tx(PSSD_GRP_NORMAL, 9'h03f, 4'h0, 1'b1);
      for (int i = 0; i < 6; i++)
      begin
         tx(PSSD_GRP_NORMAL, 9'h03f, 4'h0, 1'b0);
         `CHK(o_tx_symbols, (i == 2 || i == 4) ? 12'hffa : 12'h24e)
      end
      $display("t_srev done");
   endtask
   task automatic t_regs;
      rdchk(PSSD_ADDR_CTRL, 32'h0);
      rdchk(PSSD_ADDR_STATUS, 32'h0);
      rdchk(8'h08, 32'h0);
      wr(PSSD_ADDR_CTRL, 32'h1);
      rdchk(PSSD_ADDR_CTRL, 32'h1);
      wr(PSSD_ADDR_STATUS, 32'hffffffff);
      rdchk(PSSD_ADDR_STATUS, 32'h0);
      wr(8'h08, 32'hffffffff);
      rdchk(8'h08, 32'h0);
      wr(PSSD_ADDR_CTRL, 32'h0);
      rdchk(PSSD_ADDR_CTRL, 32'h0);
      $display("t_regs done");
   endtask
   task automatic wait_lock;
      for (int k = 0; k < 400 && o_scr_ok !== 1'b1; k++)
         @(posedge i_clk);
      #1;
      `CHK(o_scr_ok, 1'b1)
      rdchk(PSSD_ADDR_STATUS, 32'h1); // lock bit
   endtask
   task automatic t_roles;
      repeat (200) @(posedge i_clk);
      pma_master <= 1'b1;
      #1;
      `CHK(o_scr_ok, 1'b0)
      wait_lock();
      @(posedge i_clk);
      i_config_master <= 1'b0;
      pma_master <= 1'b0;
      i_loc_rcvr_ok <= 1'b0;
      @(posedge i_clk);
      i_loc_rcvr_ok <= 1'b1;
      #1;
      `CHK(o_scr_ok, 1'b0)
      wait_lock();
      $display("t_roles done");
   endtask
   task automatic t_frame(input pssd_vec_t e2, input logic ext);
      step(PSSD_SSD1, 1'b1);
      step(PSSD_SSD2, 1'b1);
      `CHK({o_rx_dv, o_rxd, o_remote_stream_active}, {1'b1, PSSD_PREAMBLE, 1'b1})
      step(12'h249, 1'b1);
      `CHK({o_rx_dv, o_rxd}, {1'b1, PSSD_PREAMBLE})
      step(12'h249, 1'b1);
      `CHK({o_rx_dv, o_rx_er}, 2'b10)
      step(PSSD_ESD1, 1'b1);
      `CHK({o_rx_dv, o_rx_er}, 2'b10)
      step(e2, 1'b1);
      `CHK(o_rx_dv, 1'b0)
      step('0, 1'b0);
      `CHK({o_rx_er, o_remote_stream_active}, {ext, ext})
      repeat (3) step('0, 1'b0);
      `CHK({o_rx_er, o_remote_stream_active}, 2'b00)
      $display("t_frame done");
   endtask
   task automatic t_abort;
      step(PSSD_SSD1, 1'b1);
      step(PSSD_SSD2, 1'b1);
      step(12'h249, 1'b1);
      step(12'h400, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
         step('0, 1'b0);
         `CHK({o_rx_dv, o_rx_er, o_rx_error_status}, 3'b111)
      end
      step('0, 1'b0);
      `CHK({o_rx_dv, o_rx_er, o_rx_error_status}, 3'b000)
      $display("t_abort done");
   endtask
   task automatic t_lpi;
      wr(PSSD_ADDR_CTRL, 32'h1);
      repeat (3) step(PSSD_LPI_IDLE, 1'b1);
      `CHK({o_rem_lpi_req, o_rxd, o_rx_er}, {1'b1, PSSD_LPI_CODE, 1'b1})
      repeat (7) step(PSSD_LPI_IDLE, 1'b1);
      `CHK(o_rem_update_done, 1'b1)
      repeat (3) step('0, 1'b0);
      wr(PSSD_ADDR_CTRL, 32'h0);
      $display("t_lpi done");
   endtask
   task automatic t_link;
      @(posedge i_clk);
      i_link_ok <= 1'b0;
      @(posedge i_clk);
      i_link_ok <= 1'b1;
      #1;
      `CHK(o_rx_er, 1'b1)
      repeat (3) step('0, 1'b0);
      `CHK(o_rx_er, 1'b0)
      $display("t_link done");
   endtask
   initial
   begin
      repeat (5) @(posedge i_clk);
      i_rst_b <= 1'b1;
      t_tx_map();
      t_srev();
      t_regs();
      t_roles();
      t_frame(PSSD_SECOND_END_GROUP_EXT0, 1'b0);
      t_frame(PSSD_SECOND_END_GROUP_EXT1, 1'b0);
      t_frame(PSSD_SECOND_END_GROUP_EXT2, 1'b1);
      t_abort();
      t_lpi();
      t_link();
      wrap_up();
   end
   initial
   begin
      repeat (5000) @(posedge i_clk);
      n_errors++;
      wrap_up();
   end
endmodule
`default_nettype wire
